/* logic/sic_core_ctrl.sv */
`timescale 1ns/1ns
`default_nettype none

// Behaviour
// - stack grows downward, push lowers pointer
// - byte push writes, pointer minus one
// - call or entry pushes address, minus two
// - byte pop reads, pointer plus one
// - return pops address, pointer plus two
// - pointer resets to last SRAM address
// - pointer bytes readable writable at 3E/3D
// - core runs on undivided input clock
// - reset and each source own vector
// - lowest vector wins among pending
// - take needs individual and global enable
// - base select moves vectors to boot
// - boot fuse moves reset vector
// - boot locks suppress interrupts by region
// - entry clears global enable
// - handler exit sets global enable
// - entry clears the serviced source flag
// - writing one clears a flag
// - flags stay latched while disabled
// - level sources request only while present
// - one instruction after handler exit first
// - CLI blocks same-cycle interrupt
// - entry four cycles, sleep adds four
// - handler exit takes four cycles
// - one instruction after SEI first
module sic_core_ctrl
    import sic_pkg::*;
(
    // Clock and reset
    input  wire logic                     clk_i,
    input  wire logic                     arst_n_i,
    // Sequencer
    input  wire logic [2:0]               op_i,
    input  wire logic                     instr_done_i,
    input  wire logic [13:0]              pc_i,
    input  wire logic [7:0]               push_data_i,
    input  wire logic                     sleeping_i,
    output logic                          busy_o,
    output logic                          vec_valid_o,
    output logic [13:0]                   vec_addr_o,
    output logic                          ret_valid_o,
    output logic [13:0]                   ret_pc_o,
    output logic [13:0]                   reset_vector_o,
    // Stack memory port
    output logic [15:0]                   mem_addr_o,
    output logic                          mem_we_o,
    output logic                          mem_re_o,
    output logic [7:0]                    mem_wdata_o,
    input  wire logic [7:0]               mem_rdata_i,
    // I/O register port
    input  wire logic [5:0]               io_addr_i,
    input  wire logic                     io_wr_i,
    input  wire logic                     io_rd_i,
    input  wire logic [7:0]               io_wdata_i,
    output logic [7:0]                    io_rdata_o,
    // Interrupt sources
    input  wire logic [SIC_IRQ_COUNT-1:0] irq_event_i,
    input  wire logic [SIC_IRQ_COUNT-1:0] irq_level_i,
    input  wire logic [SIC_IRQ_COUNT-1:0] irq_enable_i,
    input  wire logic [SIC_IRQ_COUNT-1:0] irq_flag_clr_i,
    output logic [SIC_IRQ_COUNT-1:0]      irq_flag_o,
    output logic [SIC_IRQ_COUNT-1:0]      irq_ack_o,
    // Boot configuration
    input  wire logic                     vector_base_select_i,
    input  wire logic                     boot_reset_vector_fuse_i,
    input  wire logic                     app_boot_lock_bit_i,
    input  wire logic                     loader_boot_lock_bit_i,
    // Status
    output logic [15:0]                   stack_top_pointer_o,
    output logic                          gie_o
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    sic_state_e                state;
    sic_state_e                next_state;
    logic [15:0]               stack_top_pointer;
    logic [15:0]               next_sp;
    logic                      gie;
    logic                      next_gie;
    logic                      hold_off;
    logic                      is_irq;
    logic                      is_handler_exit;
    logic [13:0]               saved_pc;
    logic [2:0]                src_idx;
    logic [2:0]                wake_cnt;
    logic [7:0]                pop_hi;
    logic [SIC_IRQ_COUNT-1:0]  hw_clr;

    // ------------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------------
    wire logic        st_idle   = (state == SIC_ST_IDLE);
    wire logic        op_push   = st_idle && (op_i == SIC_OP_PUSH);
    wire logic        op_pop    = st_idle && (op_i == SIC_OP_POP);
    wire logic        op_call   = st_idle && (op_i == SIC_OP_CALL);
    wire logic        op_ret    = st_idle && (op_i == SIC_OP_RET);
    wire logic        op_handler_exit   = st_idle && (op_i == SIC_OP_HANDLER_EXIT);
    wire logic        op_sei    = st_idle && (op_i == SIC_OP_SEI);
    wire logic        op_cli    = st_idle && (op_i == SIC_OP_CLI);
    wire logic        multi_op  = op_call || op_ret || op_handler_exit;
    wire logic        wr_sp_lo  = io_wr_i && (io_addr_i == SIC_IO_SP_LO);
    wire logic        wr_sp_hi  = io_wr_i && (io_addr_i == SIC_IO_SP_HI);
    wire logic        wr_status = io_wr_i && (io_addr_i == SIC_IO_STATUS);
    wire logic [15:0] sp_plus1  = stack_top_pointer + 16'h0001;
    wire logic [15:0] sp_plus2  = stack_top_pointer + 16'h0002;
    wire logic [15:0] sp_minus1 = stack_top_pointer - 16'h0001;
    wire logic [15:0] sp_minus2 = stack_top_pointer - 16'h0002;

    // ------------------------------------------------------------------
    // Pending requests and arbitration
    // ------------------------------------------------------------------
    // level follows condition
    wire logic [SIC_IRQ_COUNT-1:0] request =
        (irq_flag_o & ~SIC_LEVEL_MASK) | (irq_level_i & SIC_LEVEL_MASK);
    wire logic [SIC_IRQ_COUNT-1:0] pending = request & irq_enable_i;

    function automatic logic [2:0] sic_first(input logic [SIC_IRQ_COUNT-1:0] vec);
        logic [2:0] idx;
        idx = 3'h0;
        for (int i = SIC_IRQ_COUNT - 1; i >= 0; i--)
        begin
            if (vec[i])
                idx = 3'(i);
        end
        return idx;
    endfunction : sic_first

    wire logic [2:0]  win_idx   = sic_first(pending);

    // region based suppression
    // Code in the other section must not be entered from the locked one.
    wire logic        pc_in_boot = (pc_i >= SIC_BOOT_START);
    wire logic        suppress   =
        (app_boot_lock_bit_i && vector_base_select_i && !pc_in_boot) ||
        (loader_boot_lock_bit_i && !vector_base_select_i && pc_in_boot);

    wire logic        take_irq  = instr_done_i && st_idle && !multi_op && gie
                                  && !op_cli && !hold_off && !suppress
                                  && (pending != '0);

    wire logic [13:0] vec_base   = vector_base_select_i ? SIC_BOOT_START : SIC_APP_BASE;
    wire logic [13:0] vec_offset = 14'(({11'h000, src_idx} + 14'h0001) * SIC_VEC_STRIDE);

    // ------------------------------------------------------------------
    // Interrupt flags
    // ------------------------------------------------------------------
    // hardware clear on entry
    assign hw_clr = take_irq ? (SIC_IRQ_COUNT'(1) << win_idx) : '0;

    for (genvar g = 0; g < SIC_IRQ_COUNT; g++)
    begin : g_flag
        sic_irq_flag u_flag
        (
            .clk_i    (clk_i),
            .arst_n_i (arst_n_i),
            .set_i    (irq_event_i[g]),
            .sw_clr_i (irq_flag_clr_i[g]),
            .hw_clr_i (hw_clr[g]),
            .flag_o   (irq_flag_o[g])
        );
    end

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb
    begin
        next_state = state;
        case (state)
            SIC_ST_IDLE:
            begin
                if (take_irq)
                    next_state = sleeping_i ? SIC_ST_WAKE : SIC_ST_PUSH_LO;
                else if (op_call)
                    next_state = SIC_ST_PUSH_LO;
                else if (op_ret || op_handler_exit)
                    next_state = SIC_ST_POP_HI;
            end
            SIC_ST_WAKE:
            begin
                if (wake_cnt == SIC_WAKE_CYCLES - 3'h1)
                    next_state = SIC_ST_PUSH_LO;
            end
            SIC_ST_PUSH_LO: next_state = SIC_ST_PUSH_HI;
            SIC_ST_PUSH_HI: next_state = is_irq ? SIC_ST_VECTOR : SIC_ST_IDLE;
            SIC_ST_VECTOR:  next_state = SIC_ST_IDLE;
            SIC_ST_POP_HI:  next_state = SIC_ST_POP_LO;
            SIC_ST_POP_LO:  next_state = SIC_ST_RESTORE;
            SIC_ST_RESTORE: next_state = SIC_ST_IDLE;
            default:        next_state = SIC_ST_IDLE;
        endcase
    end

    // ------------------------------------------------------------------
    // Stack pointer
    // ------------------------------------------------------------------
    always_comb
    begin
        next_sp = stack_top_pointer;
        if (op_push)
            next_sp = sp_minus1;
        else if (op_pop)
            next_sp = sp_plus1;
        else if (state == SIC_ST_PUSH_HI)
            next_sp = sp_minus2;
        else if (state == SIC_ST_RESTORE)
            next_sp = sp_plus2;
        else if (wr_sp_lo)
            next_sp = {stack_top_pointer[15:8], io_wdata_i};
        else if (wr_sp_hi)
            next_sp = {io_wdata_i, stack_top_pointer[7:0]};
    end

    // ------------------------------------------------------------------
    // Global enable
    // ------------------------------------------------------------------
    always_comb
    begin
        next_gie = gie;
        if (take_irq || op_cli)
            next_gie = 1'b0;
        else if ((state == SIC_ST_RESTORE) && is_handler_exit)
            next_gie = 1'b1;
        else if (op_sei)
            next_gie = 1'b1;
        else if (wr_status)
            next_gie = io_wdata_i[SIC_GIE_BIT];
    end

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    // single undivided clock
    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            state             <= SIC_ST_IDLE;
            stack_top_pointer <= SIC_SRAM_LAST_ADDR;
            gie               <= 1'b0;
            busy_o            <= 1'b0;
        end
        else
        begin
            state             <= next_state;
            stack_top_pointer <= next_sp;
            gie               <= next_gie;
            busy_o            <= (next_state != SIC_ST_IDLE);
        end
    end

    // The blocking window ends at the next boundary, not on a timer, because
    // the following instruction may take several cycles.
    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            hold_off <= 1'b0;
        else if (op_sei || ((state == SIC_ST_RESTORE) && is_handler_exit))
            hold_off <= 1'b1;
        else if (instr_done_i)
            hold_off <= 1'b0;
    end

    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            is_irq   <= 1'b0;
            is_handler_exit  <= 1'b0;
            saved_pc <= 14'h0000;
            src_idx  <= 3'h0;
        end
        else if (st_idle)
        begin
            is_irq   <= take_irq;
            is_handler_exit  <= op_handler_exit;
            saved_pc <= pc_i;
            src_idx  <= win_idx;
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            wake_cnt <= 3'h0;
        else if (state == SIC_ST_WAKE)
            wake_cnt <= wake_cnt + 3'h1;
        else
            wake_cnt <= 3'h0;
    end

    // ------------------------------------------------------------------
    // Stack memory port
    // ------------------------------------------------------------------
    // Read data is expected one cycle after the read strobe.
    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            mem_addr_o  <= 16'h0000;
            mem_we_o    <= 1'b0;
            mem_re_o    <= 1'b0;
            mem_wdata_o <= 8'h00;
        end
        else
        begin
            mem_we_o <= op_push || (state == SIC_ST_PUSH_LO) || (state == SIC_ST_PUSH_HI);
            mem_re_o <= op_pop || op_ret || op_handler_exit || (state == SIC_ST_POP_HI);
            if (op_push)
            begin
                mem_addr_o  <= stack_top_pointer;
                mem_wdata_o <= push_data_i;
            end
            else if (op_pop || op_ret || op_handler_exit)
                mem_addr_o  <= sp_plus1;
            else if (state == SIC_ST_POP_HI)
                mem_addr_o  <= sp_plus2;
            else if (state == SIC_ST_PUSH_LO)
            begin
                mem_addr_o  <= stack_top_pointer;
                mem_wdata_o <= saved_pc[7:0];
            end
            else if (state == SIC_ST_PUSH_HI)
            begin
                mem_addr_o  <= sp_minus1;
                mem_wdata_o <= {2'b00, saved_pc[13:8]};
            end
        end
    end

    // ------------------------------------------------------------------
    // Sequencer answers
    // ------------------------------------------------------------------
    // four-cycle return
    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            pop_hi      <= 8'h00;
            ret_valid_o <= 1'b0;
            ret_pc_o    <= 14'h0000;
            vec_valid_o <= 1'b0;
            vec_addr_o  <= 14'h0000;
            irq_ack_o   <= '0;
        end
        else
        begin
            if (state == SIC_ST_POP_LO)
                pop_hi <= mem_rdata_i;
            ret_valid_o <= (state == SIC_ST_RESTORE);
            if (state == SIC_ST_RESTORE)
                ret_pc_o <= {pop_hi[5:0], mem_rdata_i};
            vec_valid_o <= (state == SIC_ST_VECTOR);
            if (state == SIC_ST_VECTOR)
                vec_addr_o <= vec_base + vec_offset;
            irq_ack_o   <= hw_clr;
        end
    end

    // ------------------------------------------------------------------
    // Reset vector and register reads
    // ------------------------------------------------------------------
    // fuse selects boot start
    // The fuse is sampled on every clock after release; the vector follows any change.
    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            reset_vector_o <= SIC_APP_BASE;
        else
            reset_vector_o <= boot_reset_vector_fuse_i ? SIC_BOOT_START : SIC_APP_BASE;
    end

    wire logic [7:0] rd_mux =
        (io_addr_i == SIC_IO_SP_LO)  ? stack_top_pointer[7:0]  :
        (io_addr_i == SIC_IO_SP_HI)  ? stack_top_pointer[15:8] :
        (io_addr_i == SIC_IO_STATUS) ? {gie, 7'h00}            : 8'h00;

    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            io_rdata_o          <= 8'h00;
            stack_top_pointer_o <= SIC_SRAM_LAST_ADDR;
            gie_o               <= 1'b0;
        end
        else
        begin
            io_rdata_o          <= io_rd_i ? rd_mux : 8'h00;
            stack_top_pointer_o <= next_sp;
            gie_o               <= next_gie;
        end
    end

endmodule : sic_core_ctrl

`default_nettype wire

/* logic/sic_pkg.sv */
package sic_pkg;

    // ------------------------------------------------------------------
    // I/O register map
    // ------------------------------------------------------------------
    localparam logic [5:0]  SIC_IO_SP_LO      = 6'h3D;
    localparam logic [5:0]  SIC_IO_SP_HI      = 6'h3E;
    localparam logic [5:0]  SIC_IO_STATUS     = 6'h3F;
    localparam int          SIC_GIE_BIT       = 7;

    // ------------------------------------------------------------------
    // Reset values and memory layout
    // ------------------------------------------------------------------
    localparam logic [15:0] SIC_SRAM_LAST_ADDR = 16'h08FF;
    localparam logic [13:0] SIC_BOOT_START     = 14'h3C00;
    localparam logic [13:0] SIC_VEC_STRIDE     = 14'h0002;
    localparam logic [13:0] SIC_APP_BASE       = 14'h0000;

    // ------------------------------------------------------------------
    // Interrupt sources
    // ------------------------------------------------------------------
    localparam int          SIC_IRQ_COUNT     = 8;
    localparam logic [7:0]  SIC_LEVEL_MASK    = 8'h01;

    // ------------------------------------------------------------------
    // Timing counts
    // ------------------------------------------------------------------
    localparam logic [2:0]  SIC_WAKE_CYCLES   = 3'h4;

    // ------------------------------------------------------------------
    // Sequencer commands and states
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        SIC_OP_NONE = 3'b000,
        SIC_OP_PUSH = 3'b001,
        SIC_OP_POP  = 3'b010,
        SIC_OP_CALL = 3'b011,
        SIC_OP_RET  = 3'b100,
        SIC_OP_HANDLER_EXIT = 3'b101,
        SIC_OP_SEI  = 3'b110,
        SIC_OP_CLI  = 3'b111
    } sic_op_e;

    typedef enum logic [2:0] {
        SIC_ST_IDLE    = 3'b000,
        SIC_ST_WAKE    = 3'b001,
        SIC_ST_PUSH_LO = 3'b010,
        SIC_ST_PUSH_HI = 3'b011,
        SIC_ST_VECTOR  = 3'b100,
        SIC_ST_POP_HI  = 3'b101,
        SIC_ST_POP_LO  = 3'b110,
        SIC_ST_RESTORE = 3'b111
    } sic_state_e;

endpackage : sic_pkg

/* logic/sic_irq_flag.sv */
`timescale 1ns/1ns
`default_nettype none

module sic_irq_flag
(
    // Clock and reset
    input  wire logic clk_i,
    input  wire logic arst_n_i,
    // Flag control
    input  wire logic set_i,
    input  wire logic sw_clr_i,
    input  wire logic hw_clr_i,
    // Flag state
    output logic      flag_o
);

    // ------------------------------------------------------------------
    // Sticky flag
    // ------------------------------------------------------------------
    // held until serviced
    // A new event in the clearing cycle must not be lost, so set wins.
    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            flag_o <= 1'b0;
        else if (set_i)
            flag_o <= 1'b1;
        else if (sw_clr_i || hw_clr_i)
            flag_o <= 1'b0;
    end

endmodule : sic_irq_flag

`default_nettype wire

/* testbench/sic_sram_model.sv */
`timescale 1ns/1ns
`default_nettype none
module sic_sram_model
(
    // Clock
    input  wire logic        clk_i,
    // Stack memory port
    input  wire logic        we_i,
    input  wire logic        re_i,
    input  wire logic [15:0] addr_i,
    input  wire logic [7:0]  wdata_i,
    output logic      [7:0]  rdata_o
);
    logic [7:0] mem [0:4095];
    initial rdata_o = 8'hA5;
    // Outside a read the bus toggles, so a late capture cannot pass by luck.
    always @(posedge clk_i)
    begin
        if (we_i)
            mem[addr_i[11:0]] <= wdata_i;
        if (re_i)
            rdata_o <= mem[addr_i[11:0]];
        else
            rdata_o <= ~rdata_o;
    end
endmodule : sic_sram_model
`default_nettype wire

/* testbench/sic_core_ctrl_sva.sv */
`timescale 1ns/1ns
`default_nettype none
module sic_core_ctrl_sva
    import sic_pkg::*;
(
    // Clock and reset
    input wire logic        clk_i,
    input wire logic        arst_n_i,
    // Sequencer
    input wire logic [2:0]  op_i,
    input wire logic        instr_done_i,
    input wire logic [7:0]  push_data_i,
    input wire logic        sleeping_i,
    input wire logic        busy_o,
    input wire logic        vec_valid_o,
    input wire logic        ret_valid_o,
    // Stack memory port
    input wire logic [15:0] mem_addr_o,
    input wire logic        mem_we_o,
    input wire logic        mem_re_o,
    input wire logic [7:0]  mem_wdata_o,
    // I/O and interrupts
    input wire logic [5:0]  io_addr_i,
    input wire logic        io_wr_i,
    input wire logic [7:0]  io_wdata_i,
    input wire logic [7:0]  irq_enable_i,
    input wire logic [7:0]  irq_ack_o,
    input wire logic [15:0] stack_top_pointer_o,
    input wire logic        gie_o
);
    wire logic [7:0] sp_hi = stack_top_pointer_o[15:8];
    wire logic       idle  = !busy_o;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!arst_n_i);
    sequence s_two_wr;
        mem_we_o ##1 mem_we_o;
    endsequence
    sequence s_two_rd;
        mem_re_o ##1 mem_re_o;
    endsequence
    a_push_dec: assert property (idle && op_i == SIC_OP_PUSH |=> mem_we_o &&
        mem_addr_o == $past(stack_top_pointer_o) && mem_wdata_o == $past(push_data_i)
        && stack_top_pointer_o == $past(stack_top_pointer_o) - 16'h0001)
        else $error("push access wrong");
    a_pop_inc: assert property (idle && op_i == SIC_OP_POP |=> mem_re_o &&
        mem_addr_o == $past(stack_top_pointer_o) + 16'h0001)
        else $error("pop access wrong");
    a_call_dec: assert property (idle && op_i == SIC_OP_CALL |-> ##2 s_two_wr ##0
        stack_top_pointer_o == $past(stack_top_pointer_o, 3) - 16'h0002)
        else $error("call push wrong");
    a_ret_inc: assert property (idle && op_i == SIC_OP_RET |=> s_two_rd ##2
        ret_valid_o && stack_top_pointer_o == $past(stack_top_pointer_o, 4) + 16'h0002)
        else $error("return pop wrong");
    a_handler_exit_gie: assert property (idle && op_i == SIC_OP_HANDLER_EXIT |-> ##4
        ret_valid_o && gie_o) else $error("handler exit wrong");
    a_take_gie: assert property ((|irq_ack_o) |-> !gie_o && $past(gie_o) &&
        (irq_ack_o & $past(irq_enable_i)) != 8'h00) else $error("take not allowed");
    a_vec_lat: assert property ((|irq_ack_o) && !$past(sleeping_i) |->
        ##1 s_two_wr ##1 vec_valid_o) else $error("vector late");
    a_cli_block: assert property (idle && op_i == SIC_OP_CLI |=>
        irq_ack_o == 8'h00 && !gie_o) else $error("take after disable");
    a_sp_lo_wr: assert property (idle && io_wr_i && io_addr_i == SIC_IO_SP_LO &&
        op_i == SIC_OP_NONE && !instr_done_i |=> sp_hi == $past(sp_hi) &&
        stack_top_pointer_o[7:0] == $past(io_wdata_i)) else $error("low byte write wrong");
endmodule : sic_core_ctrl_sva
bind sic_core_ctrl sic_core_ctrl_sva i_sic_core_ctrl_sva (.clk_i, .arst_n_i, .op_i,
    .instr_done_i, .push_data_i, .sleeping_i, .busy_o, .vec_valid_o, .ret_valid_o,
    .mem_addr_o, .mem_we_o, .mem_re_o, .mem_wdata_o, .io_addr_i, .io_wr_i, .io_wdata_i,
    .irq_enable_i, .irq_ack_o, .stack_top_pointer_o, .gie_o);
`default_nettype wire

/* testbench/test_stack_and_interrupt_control.sv */
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin err_total++; \
    $display("[ERR] %0t got %h exp %h", $time, (a), (e)); end end
module test_stack_and_interrupt_control;
    import sic_pkg::*;
    logic clk_i, arst_n_i, instr_done_i, sleeping_i, busy_o, vec_valid_o, ret_valid_o;
    logic io_wr_i, io_rd_i, mem_we_o, mem_re_o, gie_o, vector_base_select_i;
    logic boot_reset_vector_fuse_i, app_boot_lock_bit_i, loader_boot_lock_bit_i;
    logic [2:0]  op_i;
    logic [5:0]  io_addr_i;
    logic [13:0] pc_i, vec_addr_o, ret_pc_o, reset_vector_o;
    logic [15:0] mem_addr_o, stack_top_pointer_o;
    logic [7:0]  push_data_i, mem_wdata_o, mem_rdata_i, io_wdata_i, io_rdata_o;
    logic [7:0]  irq_event_i, irq_level_i, irq_enable_i, irq_flag_clr_i, irq_flag_o, irq_ack_o;
    int err_total, total_checks, cycles;
    sic_core_ctrl i_sic_core_ctrl (.clk_i, .arst_n_i, .op_i, .instr_done_i, .pc_i,
        .push_data_i, .sleeping_i, .busy_o, .vec_valid_o, .vec_addr_o, .ret_valid_o,
        .ret_pc_o, .reset_vector_o, .mem_addr_o, .mem_we_o, .mem_re_o, .mem_wdata_o,
        .mem_rdata_i, .io_addr_i, .io_wr_i, .io_rd_i, .io_wdata_i, .io_rdata_o,
        .irq_event_i, .irq_level_i, .irq_enable_i, .irq_flag_clr_i, .irq_flag_o,
        .irq_ack_o, .vector_base_select_i, .boot_reset_vector_fuse_i,
        .app_boot_lock_bit_i, .loader_boot_lock_bit_i, .stack_top_pointer_o, .gie_o);
    sic_sram_model i_sic_sram_model (.clk_i, .we_i(mem_we_o), .re_i(mem_re_o),
        .addr_i(mem_addr_o), .wdata_i(mem_wdata_o), .rdata_o(mem_rdata_i));
    initial
    begin
        clk_i = 1'b0;
        forever #10 clk_i = ~clk_i;
    end
    task tick; @(posedge clk_i); #1; endtask : tick
    task cmd(input logic [2:0] o, input logic d);
        op_i = o; instr_done_i = d; tick();
        op_i = SIC_OP_NONE; instr_done_i = 1'b0;
    endtask : cmd
    task io_wr(input logic [5:0] a, input logic [7:0] d);
        io_addr_i = a; io_wdata_i = d; io_wr_i = 1'b1; tick(); io_wr_i = 1'b0;
    endtask : io_wr
    task io_rd(input logic [5:0] a, input logic [7:0] e);
        io_addr_i = a; io_rd_i = 1'b1; tick(); io_rd_i = 1'b0;
        `CHK(io_rdata_o, e)
    endtask : io_rd
    task wait_vec(input logic [13:0] e);
        for (int n = 0; n < 20 && vec_valid_o !== 1'b1; n++) tick();
        `CHK(vec_addr_o, e)
    endtask : wait_vec
    task wait_ret(input logic [13:0] e);
        for (int n = 0; n < 20 && ret_valid_o !== 1'b1; n++) tick();
        `CHK(ret_pc_o, e)
    endtask : wait_ret
    task t_stack;
        `CHK(stack_top_pointer_o, SIC_SRAM_LAST_ADDR)
        `CHK(reset_vector_o, 14'h0000)
        io_wr(SIC_IO_SP_LO, 8'h55); `CHK(stack_top_pointer_o, 16'h0855)
        io_wr(SIC_IO_SP_HI, 8'h07); `CHK(stack_top_pointer_o, 16'h0755)
        io_rd(SIC_IO_SP_LO, 8'h55); io_rd(SIC_IO_SP_HI, 8'h07);
        io_rd(6'h10, 8'h00);
        push_data_i = 8'hAB; cmd(SIC_OP_PUSH, 1'b1);
        `CHK(mem_addr_o, 16'h0755) `CHK(stack_top_pointer_o, 16'h0754)
        cmd(SIC_OP_POP, 1'b1);
        `CHK(i_sic_sram_model.mem[12'h755], 8'hAB) `CHK(mem_re_o, 1'b1)
        `CHK(mem_addr_o, 16'h0755) `CHK(stack_top_pointer_o, 16'h0755)
        pc_i = 14'h1234; cmd(SIC_OP_CALL, 1'b0); tick(); tick(); tick();
        `CHK(stack_top_pointer_o, 16'h0753)
        `CHK(i_sic_sram_model.mem[12'h754], 8'h12)
        cmd(SIC_OP_RET, 1'b0); wait_ret(14'h1234);
        `CHK(stack_top_pointer_o, 16'h0755)
        $display("test stack done");
    endtask : t_stack
    task t_irq;
        irq_event_i = 8'h24; tick(); irq_event_i = 8'h00;
        `CHK(irq_flag_o, 8'h24)
        io_wr(SIC_IO_STATUS, 8'h80); cmd(SIC_OP_NONE, 1'b1); `CHK(irq_ack_o, 8'h00)
        irq_enable_i = 8'h24; cmd(SIC_OP_CLI, 1'b1); `CHK(irq_ack_o, 8'h00)
        cmd(SIC_OP_SEI, 1'b1); cmd(SIC_OP_NONE, 1'b1); `CHK(irq_ack_o, 8'h00)
        pc_i = 14'h0100; cmd(SIC_OP_NONE, 1'b1); `CHK(irq_ack_o, 8'h04)
        `CHK(gie_o, 1'b0) `CHK(irq_flag_o, 8'h20)
        wait_vec(14'h0006);
        `CHK(stack_top_pointer_o, 16'h0753)
        cmd(SIC_OP_HANDLER_EXIT, 1'b0); wait_ret(14'h0100); `CHK(gie_o, 1'b1)
        vector_base_select_i = 1'b1;
        cmd(SIC_OP_NONE, 1'b1); `CHK(irq_ack_o, 8'h00)
        cmd(SIC_OP_NONE, 1'b1); `CHK(irq_ack_o, 8'h20)
        wait_vec(14'h3C0C);
        cmd(SIC_OP_HANDLER_EXIT, 1'b0); wait_ret(14'h0100);
        irq_enable_i = 8'h00; irq_level_i = 8'h01; tick(); irq_level_i = 8'h00;
        irq_enable_i = 8'h01; cmd(SIC_OP_NONE, 1'b1);
        cmd(SIC_OP_NONE, 1'b1); `CHK(irq_ack_o, 8'h00)
        irq_level_i = 8'h01; app_boot_lock_bit_i = 1'b1;
        cmd(SIC_OP_NONE, 1'b1); `CHK(irq_ack_o, 8'h00)
        app_boot_lock_bit_i = 1'b0; sleeping_i = 1'b1;
        cmd(SIC_OP_NONE, 1'b1); `CHK(irq_ack_o, 8'h01)
        irq_level_i = 8'h00; sleeping_i = 1'b0; wait_vec(14'h3C02);
        irq_event_i = 8'h08; tick(); irq_event_i = 8'h00; `CHK(irq_flag_o, 8'h08)
        irq_flag_clr_i = 8'h08; tick(); irq_flag_clr_i = 8'h00;
        `CHK(irq_flag_o, 8'h00)
        boot_reset_vector_fuse_i = 1'b1; tick(); `CHK(reset_vector_o, SIC_BOOT_START)
        $display("test interrupt done");
    endtask : t_irq
    task final_report;
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : final_report
    // A hang must still end in one verdict.
    always @(posedge clk_i)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            err_total++;
            final_report();
        end
    end
    initial
    begin
        {arst_n_i, instr_done_i, sleeping_i, io_wr_i, io_rd_i, vector_base_select_i} = '0;
        {boot_reset_vector_fuse_i, app_boot_lock_bit_i, loader_boot_lock_bit_i} = '0;
        op_i = SIC_OP_NONE; io_addr_i = '0; pc_i = '0; push_data_i = '0; io_wdata_i = '0;
        {irq_event_i, irq_level_i, irq_enable_i, irq_flag_clr_i} = '0;
        repeat (5) @(posedge clk_i);
        #1 arst_n_i = 1'b1;
        tick();
        t_stack();
        t_irq();
        final_report();
    end
endmodule : test_stack_and_interrupt_control
`default_nettype wire
